// *** gpei_top.v ***
// gpio ports with edge interrupts, pull-ups, sink levels and rc wake pin
`timescale 1ns/1ps
// What this block does
// - eight low-current lines plus high-current port
// - small variant keeps high lines zero to three
// - every line may interrupt the core
// - edge triggered, polarity chosen per line
// - per-line pull-up, independently switched
// - four-bit sink level per line
// - high-current port drivers programmable for leds
// - rc pin open-drain, schmitt input
// - rc pin rising edge raises own interrupt
// - rc pin interrupt ends suspend
// - port data registers at indices 0x00, 0x01
// - write-only interrupt enables at 0x04, 0x05
// - write-only pull-up controls at 0x08, 0x09
// - line vector 0x000C, rc pin vector 0x000E
`include "gpei_map.vh"
module gpei_top #(
  parameter HI_LINES = 8
) (
  clk,
  rst_n,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  lo_in,
  lo_out,
  lo_oe_n,
  lo_pullup_en,
  lo_sink_level,
  hi_in,
  hi_out,
  hi_oe_n,
  hi_pullup_en,
  hi_sink_level,
  cext_in,
  cext_out,
  cext_oe_n,
  irq,
  line_irq_req,
  cext_irq_req,
  line_irq_vec,
  cext_irq_vec,
  suspended
);
  input wire clk;
  input wire rst_n;
  input wire [7:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  input wire [3:0] avs_byteenable;
  output wire [31:0] avs_readdata;
  output wire avs_waitrequest;
  input wire [7:0] lo_in;
  output wire [7:0] lo_out;
  output wire [7:0] lo_oe_n;
  output wire [7:0] lo_pullup_en;
  output wire [31:0] lo_sink_level;
  input wire [7:0] hi_in;
  output wire [7:0] hi_out;
  output wire [7:0] hi_oe_n;
  output wire [7:0] hi_pullup_en;
  output wire [31:0] hi_sink_level;
  input wire cext_in;
  output wire cext_out;
  output wire cext_oe_n;
  output wire irq;
  output wire line_irq_req;
  output wire cext_irq_req;
  output wire [15:0] line_irq_vec;
  output wire [15:0] cext_irq_vec;
  output wire suspended;

  // ----------------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_int_n;

  // assert at once, release only after two clean edges
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_int_n = rst_sync_q;

  // ----------------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------------
  reg [7:0] lo_data_q;
  reg [7:0] hi_data_q;
  reg [7:0] lo_pol_q;
  reg [7:0] hi_pol_q;
  reg [7:0] lo_ie_q;
  reg [7:0] hi_ie_q;
  reg [7:0] lo_pu_q;
  reg [7:0] hi_pu_q;
  reg [31:0] lo_lvl_q;
  reg [31:0] hi_lvl_q;
  reg [`GPEI_STAT_W-1:0] status_q;
  reg [`GPEI_STAT_W-1:0] status_d;
  reg [`GPEI_STAT_W-1:0] mask_q;
  reg [1:0] ctrl_q;
  reg ack_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg [15:0] line_prev_q;
  reg cext_prev_q;

  // ----------------------------------------------------------------------------
  // variant mask: absent high lines are never driven and never interrupt
  // ----------------------------------------------------------------------------
  wire [7:0] hi_impl;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_impl
      assign hi_impl[gi] = (gi < HI_LINES) ? 1'b1 : 1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // avalon slave handshake
  // ----------------------------------------------------------------------------
  wire req;
  wire accept;
  wire [5:0] idx;
  wire [31:0] be_mask;
  wire [31:0] wmask;

  // one wait cycle: data are looked up, then the access completes
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign accept = req & ack_q;
  assign idx = avs_address[7:2];
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wmask = (accept & avs_write) ? be_mask : 32'h00000000;
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------------------
  wire [15:0] line_sync;
  wire [0:0] cext_sync;
  wire [15:0] line_edge;
  wire [15:0] line_impl;
  wire [15:0] line_ie;
  wire [15:0] line_pol;
  wire cext_rise;

  gpei_sync #(.W(16)) u_line_sync (
    .clk(clk),
    .rst_n(rst_int_n),
    .d({hi_in, lo_in}),
    .q(line_sync)
  );
  gpei_sync #(.W(1)) u_cext_sync (
    .clk(clk),
    .rst_n(rst_int_n),
    .d(cext_in),
    .q(cext_sync)
  );

  assign line_impl = {hi_impl, 8'hFF};
  assign line_ie = {hi_ie_q, lo_ie_q} & line_impl;
  assign line_pol = {hi_pol_q, lo_pol_q};

  // polarity bit high picks the rising edge, low the falling edge
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_edge
      assign line_edge[gi] = line_pol[gi] ? (line_sync[gi] & ~line_prev_q[gi]) :
                             (~line_sync[gi] & line_prev_q[gi]);
    end
  endgenerate

  // pad hysteresis is analogue; only rising edges of the clean level count
  assign cext_rise = cext_sync[0] & ~cext_prev_q;

  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      line_prev_q <= 16'h0000;
      cext_prev_q <= 1'b0;
    end else begin
      line_prev_q <= line_sync;
      cext_prev_q <= cext_sync[0];
    end
  end

  // ----------------------------------------------------------------------------
  // read data lookup, taken in the wait cycle
  // ----------------------------------------------------------------------------
  // write-only and unmapped locations read as zero
  always @* begin
    rdata_d = 32'h00000000;
    case (idx)
      `GPEI_IDX_LO_DATA: rdata_d = {24'h000000, line_sync[7:0]};
      `GPEI_IDX_HI_DATA: rdata_d = {24'h000000, line_sync[15:8] & hi_impl};
      `GPEI_IDX_LO_POL: rdata_d = {24'h000000, lo_pol_q};
      `GPEI_IDX_HI_POL: rdata_d = {24'h000000, hi_pol_q};
      `GPEI_IDX_LO_LVL: rdata_d = lo_lvl_q;
      `GPEI_IDX_HI_LVL: rdata_d = hi_lvl_q;
      `GPEI_IDX_STATUS: rdata_d = {15'h0000, status_q};
      `GPEI_IDX_MASK: rdata_d = {15'h0000, mask_q};
      `GPEI_IDX_CTRL: rdata_d = {30'h00000000, ctrl_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------------
  // pending status: set by edges, cleared by reading it
  // ----------------------------------------------------------------------------
  wire [`GPEI_STAT_W-1:0] stat_set;
  wire [`GPEI_STAT_W-1:0] stat_clr;

  assign stat_set = {cext_rise, line_edge & line_ie};
  // only bits already seen by the reader are cleared, later edges survive
  assign stat_clr = (accept & avs_read & (idx == `GPEI_IDX_STATUS)) ?
                    rdata_q[`GPEI_STAT_W-1:0] : {`GPEI_STAT_W{1'b0}};

  // set wins over clear in the same cycle
  always @* begin
    status_d = (status_q & ~stat_clr) | stat_set;
  end

  // ----------------------------------------------------------------------------
  // register writes and bus state
  // ----------------------------------------------------------------------------
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      lo_data_q <= `GPEI_DATA_RST;
      hi_data_q <= `GPEI_DATA_RST;
      lo_pol_q <= `GPEI_POL_RST;
      hi_pol_q <= `GPEI_POL_RST;
      lo_ie_q <= `GPEI_IE_RST;
      hi_ie_q <= `GPEI_IE_RST;
      lo_pu_q <= `GPEI_PU_RST;
      hi_pu_q <= `GPEI_PU_RST;
      lo_lvl_q <= `GPEI_LVL_RST;
      hi_lvl_q <= `GPEI_LVL_RST;
      status_q <= {`GPEI_STAT_W{1'b0}};
      mask_q <= `GPEI_MASK_RST;
      ctrl_q <= `GPEI_CTRL_RST;
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        rdata_q <= rdata_d;
      end
      status_q <= status_d;
      // wmask[7:0] is all ones or all zeros, so bit 0 stands for the low byte
      case (idx)
        `GPEI_IDX_LO_DATA: lo_data_q <= wmask[0] ? avs_writedata[7:0] : lo_data_q;
        `GPEI_IDX_HI_DATA: hi_data_q <= wmask[0] ? avs_writedata[7:0] : hi_data_q;
        `GPEI_IDX_LO_POL: lo_pol_q <= wmask[0] ? avs_writedata[7:0] : lo_pol_q;
        `GPEI_IDX_HI_POL: hi_pol_q <= wmask[0] ? avs_writedata[7:0] : hi_pol_q;
        `GPEI_IDX_LO_IE: lo_ie_q <= wmask[0] ? avs_writedata[7:0] : lo_ie_q;
        `GPEI_IDX_HI_IE: hi_ie_q <= wmask[0] ? avs_writedata[7:0] : hi_ie_q;
        `GPEI_IDX_LO_PU: lo_pu_q <= wmask[0] ? avs_writedata[7:0] : lo_pu_q;
        `GPEI_IDX_HI_PU: hi_pu_q <= wmask[0] ? avs_writedata[7:0] : hi_pu_q;
        `GPEI_IDX_LO_LVL: begin
          lo_lvl_q <= (lo_lvl_q & ~wmask) | (avs_writedata & wmask);
        end
        `GPEI_IDX_HI_LVL: begin
          hi_lvl_q <= (hi_lvl_q & ~wmask) | (avs_writedata & wmask);
        end
        `GPEI_IDX_MASK: begin
          mask_q <= (mask_q & ~wmask[16:0]) | (avs_writedata[16:0] & wmask[16:0]);
        end
        `GPEI_IDX_CTRL: begin
          ctrl_q[`GPEI_CTRL_CEXT_LOW] <= wmask[`GPEI_CTRL_CEXT_LOW] ?
                                         avs_writedata[`GPEI_CTRL_CEXT_LOW] :
                                         ctrl_q[`GPEI_CTRL_CEXT_LOW];
        end
        default: ctrl_q <= ctrl_q;
      endcase
      // wake beats a suspend write in the same cycle, so no wake is missed
      if (cext_rise) begin
        ctrl_q[`GPEI_CTRL_SUSPEND] <= 1'b0;
      end else if ((idx == `GPEI_IDX_CTRL) & wmask[`GPEI_CTRL_SUSPEND]) begin
        ctrl_q[`GPEI_CTRL_SUSPEND] <= avs_writedata[`GPEI_CTRL_SUSPEND];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // pin drivers: a zero data bit sinks the line, a one releases it
  // ----------------------------------------------------------------------------
  assign lo_out = 8'h00;
  assign hi_out = 8'h00;
  assign lo_oe_n = lo_data_q;
  assign hi_oe_n = hi_data_q | ~hi_impl;
  assign lo_pullup_en = lo_pu_q;
  assign hi_pullup_en = hi_pu_q & hi_impl;

  // sink level nibbles, zeroed for absent lines
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_lvl
      assign lo_sink_level[4*gi+3:4*gi] = lo_lvl_q[4*gi+3:4*gi];
      assign hi_sink_level[4*gi+3:4*gi] = hi_lvl_q[4*gi+3:4*gi] &
                                          {4{hi_impl[gi]}};
    end
  endgenerate

  // rc pin only ever pulls low, letting the external network charge it
  assign cext_out = 1'b0;
  assign cext_oe_n = ~ctrl_q[`GPEI_CTRL_CEXT_LOW];

  // ----------------------------------------------------------------------------
  // interrupt outputs
  // ----------------------------------------------------------------------------
  assign line_irq_req = |status_q[15:0];
  assign cext_irq_req = status_q[`GPEI_STAT_CEXT];
  assign irq = |(status_q & mask_q);
  assign line_irq_vec = `GPEI_VEC_LINE;
  assign cext_irq_vec = `GPEI_VEC_CEXT;
  assign suspended = ctrl_q[`GPEI_CTRL_SUSPEND];
endmodule

// *** gpei_map.vh ***
// register indices, field positions, reset values and vectors of the gpio block
`ifndef GPEI_MAP_VH
`define GPEI_MAP_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define GPEI_IDX_LO_DATA 6'h00
`define GPEI_IDX_HI_DATA 6'h01
`define GPEI_IDX_LO_POL 6'h02
`define GPEI_IDX_HI_POL 6'h03
`define GPEI_IDX_LO_IE 6'h04
`define GPEI_IDX_HI_IE 6'h05
`define GPEI_IDX_LO_LVL 6'h06
`define GPEI_IDX_HI_LVL 6'h07
`define GPEI_IDX_LO_PU 6'h08
`define GPEI_IDX_HI_PU 6'h09
`define GPEI_IDX_STATUS 6'h0C
`define GPEI_IDX_MASK 6'h0D
`define GPEI_IDX_CTRL 6'h0E

// ----------------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------------
`define GPEI_STAT_W 17
`define GPEI_STAT_CEXT 16
`define GPEI_CTRL_SUSPEND 0
`define GPEI_CTRL_CEXT_LOW 1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define GPEI_DATA_RST 8'hFF
`define GPEI_POL_RST 8'h00
`define GPEI_IE_RST 8'h00
`define GPEI_PU_RST 8'h00
`define GPEI_LVL_RST 32'h00000000
`define GPEI_MASK_RST 17'h00000
`define GPEI_CTRL_RST 2'h0

// ----------------------------------------------------------------------------
// interrupt vector addresses
// ----------------------------------------------------------------------------
`define GPEI_VEC_LINE 16'h000C
`define GPEI_VEC_CEXT 16'h000E

`endif

// *** gpei_sync.v ***
// two flip-flop synchroniser, one chain per bit
`timescale 1ns/1ps
module gpei_sync #(
  parameter W = 8
) (
  clk,
  rst_n,
  d,
  q
);
  input wire clk;
  input wire rst_n;
  input wire [W-1:0] d;
  output wire [W-1:0] q;

  // ----------------------------------------------------------------------------
  // synchroniser chains
  // ----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      // first stage feeds only the second stage, never any logic
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate
endmodule

// *** gpei_dummy_unused.v ***
// spare design unit: holds no logic, the block needs only two modules
`timescale 1ns/1ps

// *** gpei_checker.sv ***
// concurrent checks on the ports of the gpio block
`timescale 1ns/1ps
module gpei_checker #(
  parameter HI_LINES = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [7:0] lo_out,
  input wire [7:0] hi_out,
  input wire [7:0] hi_oe_n,
  input wire [7:0] hi_pullup_en,
  input wire cext_in,
  input wire cext_out,
  input wire irq,
  input wire line_irq_req,
  input wire cext_irq_req,
  input wire [15:0] line_irq_vec,
  input wire [15:0] cext_irq_vec,
  input wire suspended
);
  // status reads are the only legal way for pending bits to fall
  wire st_rd = avs_read && (avs_address[7:2] == 6'h0C);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // bus timing
  // ----------------------------------------------------------------
  chk_wait_once: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait lasted more than one cycle");
  chk_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("no wait cycle on a new request");
  // ----------------------------------------------------------------
  // pins and interrupts
  // ----------------------------------------------------------------
  chk_vec_fixed: assert property (line_irq_vec == 16'h000C && cext_irq_vec == 16'h000E)
    else $error("interrupt vector wrong");
  chk_sink_only: assert property (lo_out == 8'h00 && hi_out == 8'h00 && !cext_out)
    else $error("pin driven high");
  chk_hi_absent: assert property (((hi_oe_n >> HI_LINES) == (8'hFF >> HI_LINES)) &&
      ((hi_pullup_en >> HI_LINES) == 8'h00))
    else $error("absent high line active");
  chk_irq_cause: assert property (irq |-> line_irq_req || cext_irq_req)
    else $error("irq without pending request");
  chk_wake_ends: assert property ($rose(cext_irq_req) |-> !suspended)
    else $error("wake pin rise left suspend on");
  chk_sync_delay: assert property ($rose(cext_irq_req) |-> $past(cext_in, 3) && !$past(cext_in, 4))
    else $error("wake pin request not three cycles after pin rise");
  chk_cext_hold: assert property (cext_irq_req && !st_rd |=> cext_irq_req)
    else $error("wake pin request dropped without status read");
  chk_line_hold: assert property (line_irq_req && !st_rd |=> line_irq_req)
    else $error("line request dropped without status read");
  cov_irq: cover property (irq);
  cov_wake: cover property ($fell(suspended));
  cov_masked: cover property (line_irq_req && !irq);
endmodule

// *** gpei_pins.sv ***
// pin-side model: switches, pull-ups and an rc network on the wake pin
`timescale 1ns/1ps
module gpei_pins #(
  parameter RC_CYC = 20
) (
  input wire clk,
  input wire [7:0] lo_oe_n,
  input wire [7:0] lo_pullup_en,
  input wire [7:0] lo_sw,
  input wire [7:0] lo_sw_en,
  input wire [7:0] hi_oe_n,
  input wire [7:0] hi_pullup_en,
  input wire [7:0] hi_sw,
  input wire [7:0] hi_sw_en,
  input wire cext_oe_n,
  output wire [7:0] lo_in,
  output wire [7:0] hi_in,
  output wire cext_in
);
  reg tog = 1'b0;
  integer chg = 0;
  // floating lines wobble every cycle so a missing pull-up shows; the cap
  // discharges while the pin sinks and charges slowly once released
  always @(posedge clk) begin
    tog <= ~tog;
    chg <= cext_oe_n ? chg + 1 : 0;
  end
  // a sinking pin wins over switches and pull-ups
  assign lo_in = lo_oe_n & ((lo_sw_en & lo_sw) | (~lo_sw_en & (lo_pullup_en | {8{tog}})));
  assign hi_in = hi_oe_n & ((hi_sw_en & hi_sw) | (~hi_sw_en & (hi_pullup_en | {8{tog}})));
  assign cext_in = cext_oe_n & (chg >= RC_CYC);
endmodule

// *** test_gpei.sv ***
// self-checking bench for the gpio block
`timescale 1ns/1ps
`include "gpei_map.vh"
module test_gpei;
  localparam HI_LINES = 4;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] avs_address = 8'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  reg [7:0] lo_sw = 8'hFF;
  reg [7:0] lo_sw_en = 8'hFF;
  reg [7:0] hi_sw = 8'hFF;
  reg [7:0] hi_sw_en = 8'hFF;
  wire [31:0] avs_readdata, lo_sink_level, hi_sink_level;
  wire [7:0] lo_in, lo_out, lo_oe_n, lo_pullup_en, hi_in, hi_out, hi_oe_n, hi_pullup_en;
  wire [15:0] line_irq_vec, cext_irq_vec;
  wire avs_waitrequest, cext_in, cext_out, cext_oe_n, irq, line_irq_req, cext_irq_req, suspended;
  integer err_total = 0;
  integer total_checks = 0;
  integer cyc = 0;
  reg [31:0] rd;
  gpei_top #(.HI_LINES(HI_LINES)) uut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lo_in(lo_in),
    .lo_out(lo_out), .lo_oe_n(lo_oe_n), .lo_pullup_en(lo_pullup_en),
    .lo_sink_level(lo_sink_level), .hi_in(hi_in), .hi_out(hi_out), .hi_oe_n(hi_oe_n),
    .hi_pullup_en(hi_pullup_en), .hi_sink_level(hi_sink_level), .cext_in(cext_in),
    .cext_out(cext_out), .cext_oe_n(cext_oe_n), .irq(irq), .line_irq_req(line_irq_req),
    .cext_irq_req(cext_irq_req), .line_irq_vec(line_irq_vec), .cext_irq_vec(cext_irq_vec),
    .suspended(suspended));
  gpei_pins u_pins (
    .clk(clk), .lo_oe_n(lo_oe_n), .lo_pullup_en(lo_pullup_en), .lo_sw(lo_sw),
    .lo_sw_en(lo_sw_en), .hi_oe_n(hi_oe_n), .hi_pullup_en(hi_pullup_en), .hi_sw(hi_sw),
    .hi_sw_en(hi_sw_en), .cext_oe_n(cext_oe_n), .lo_in(lo_in), .hi_in(hi_in),
    .cext_in(cext_in));
  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // a hung handshake ends the run as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      final_report;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // ----------------------------------------------------------------
  // bus master: request held to the rising edge that sees waitrequest low
  // ----------------------------------------------------------------
  task bus(input r, input [5:0] idx, input [31:0] d);
    begin
      avs_address <= {idx, 2'b00};
      avs_read <= r;
      avs_write <= ~r;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // one idle edge lets outputs settle and keeps each strobe single-driven
      @(posedge clk);
    end
  endtask
  task wr(input [5:0] idx, input [31:0] d);
    bus(1'b0, idx, d);
  endtask
  task rchk(input [5:0] idx, input [31:0] exp);
    begin
      bus(1'b1, idx, 32'h00000000);
      chk(rd, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset state; the wake pin charges after reset and flags once
    chk({lo_oe_n, hi_oe_n, lo_pullup_en, hi_pullup_en}, 32'hFFFF0000);
    rchk(`GPEI_IDX_LO_POL, 32'h00000000);
    rchk(`GPEI_IDX_MASK, 32'h00000000);
    rchk(`GPEI_IDX_LO_LVL, 32'h00000000);
    rchk(`GPEI_IDX_HI_DATA, 32'h0000000F);
    rchk(6'h3F, 32'h00000000);
    repeat (30) @(posedge clk);
    rchk(`GPEI_IDX_STATUS, 32'h00010000);
    $display("test reset done");
    // output latches sink pins; read back shows pin levels
    wr(`GPEI_IDX_LO_DATA, 32'h0000005A);
    wr(`GPEI_IDX_HI_DATA, 32'h0000000A);
    chk({lo_oe_n, hi_oe_n}, 16'h5AFA);
    repeat (3) @(posedge clk);
    rchk(`GPEI_IDX_LO_DATA, 32'h0000005A);
    rchk(`GPEI_IDX_HI_DATA, 32'h0000000A);
    wr(`GPEI_IDX_LO_DATA, 32'h000000FF);
    wr(`GPEI_IDX_HI_DATA, 32'h000000FF);
    $display("test data done");
    // pull-ups hold released lines, write-only places read zero
    lo_sw_en <= 8'h00;
    wr(`GPEI_IDX_LO_PU, 32'h000000FF);
    wr(`GPEI_IDX_HI_PU, 32'h000000FF);
    chk({lo_pullup_en, hi_pullup_en}, 16'hFF0F);
    repeat (6) @(posedge clk);
    rchk(`GPEI_IDX_LO_DATA, 32'h000000FF);
    rchk(`GPEI_IDX_LO_PU, 32'h00000000);
    lo_sw_en <= 8'hFF;
    wr(`GPEI_IDX_LO_LVL, 32'hFEDCBA98);
    wr(`GPEI_IDX_HI_LVL, 32'hFFFFFFFF);
    chk(lo_sink_level, 32'hFEDCBA98);
    chk(hi_sink_level, 32'h0000FFFF);
    rchk(`GPEI_IDX_LO_LVL, 32'hFEDCBA98);
    $display("test pullup done");
    // edges with per-line polarity, a short pulse kept pending
    wr(`GPEI_IDX_LO_POL, 32'h0000000F);
    wr(`GPEI_IDX_LO_IE, 32'h000000FF);
    wr(`GPEI_IDX_MASK, 32'h0001FFFF);
    rchk(`GPEI_IDX_LO_IE, 32'h00000000);
    lo_sw <= 8'h00;
    repeat (6) @(posedge clk);
    chk({irq, line_irq_req}, 2'b11);
    rchk(`GPEI_IDX_STATUS, 32'h000000F0);
    rchk(`GPEI_IDX_STATUS, 32'h00000000);
    lo_sw <= 8'hFF;
    repeat (2) @(posedge clk);
    lo_sw <= 8'h00;
    repeat (6) @(posedge clk);
    rchk(`GPEI_IDX_STATUS, 32'h000000FF);
    // disabled lines are dropped, mask only hides the combined output
    wr(`GPEI_IDX_HI_IE, 32'h00000001);
    wr(`GPEI_IDX_MASK, 32'h00000000);
    hi_sw <= 8'h00;
    repeat (6) @(posedge clk);
    chk({irq, line_irq_req}, 2'b01);
    rchk(`GPEI_IDX_STATUS, 32'h00000100);
    $display("test edge done");
    // wake pin sinks, then the rc rise ends suspend
    wr(`GPEI_IDX_MASK, 32'h00010000);
    wr(`GPEI_IDX_CTRL, 32'h00000003);
    chk({suspended, cext_oe_n, cext_in}, 3'b100);
    repeat (4) @(posedge clk);
    wr(`GPEI_IDX_CTRL, 32'h00000001);
    repeat (30) @(posedge clk);
    chk({irq, cext_irq_req, suspended}, 3'b110);
    rchk(`GPEI_IDX_STATUS, 32'h00010000);
    rchk(`GPEI_IDX_CTRL, 32'h00000000);
    $display("test wake done");
    final_report;
  end
endmodule
bind gpei_top gpei_checker #(.HI_LINES(HI_LINES)) u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .lo_out(lo_out),
  .hi_out(hi_out), .hi_oe_n(hi_oe_n), .hi_pullup_en(hi_pullup_en), .cext_in(cext_in),
  .cext_out(cext_out), .irq(irq), .line_irq_req(line_irq_req), .cext_irq_req(cext_irq_req),
  .line_irq_vec(line_irq_vec), .cext_irq_vec(cext_irq_vec), .suspended(suspended));
